// >>> core/ems_lane_steer.sv
// Endian lane steering and reset sequencing for the external memory iface
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Endian select pin picks little or big
// - Little endian: narrow data on low lanes
// - Big endian, fix pin high: top lanes
// - Fix pin low: narrow data always low
// - Fix pin ignored in little endian
// - External reset low holds internal reset
// - Internal reset release starts configured boot
module ems_lane_steer
    import ems_pkg::*;
#(
    parameter int HOLD_CYC = EMS_RST_HOLD_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Configuration pins
    input wire logic i_endian_select_pin,
    input wire logic i_lane_correct_pin,
    input wire logic [1:0] i_boot_mode_pin,
    // Reset and boot outputs
    output logic o_int_rst_n,
    output logic o_cpu_start,
    output logic [1:0] o_boot_mode,
    output logic o_little_endian_mode,
    output logic o_big_endian_lane_fix,
    // Core access port
    input wire logic i_acc_req,
    input wire logic i_acc_we,
    input wire logic [1:0] i_acc_width,
    input wire logic [31:0] i_acc_wdata,
    output logic o_acc_ready,
    output logic o_acc_done,
    output logic [31:0] o_acc_rdata,
    // External data bus pins
    input wire logic [31:0] i_ext_data_bus,
    output logic [31:0] o_ext_data_bus,
    output logic [3:0] o_ext_data_oe
);
    localparam int HCW = $clog2(HOLD_CYC + 1);
    localparam logic [HCW-1:0] HOLD_LAST = HCW'(HOLD_CYC - 1);
    localparam logic [1:0] RD_LAST = 2'(EMS_RD_WAIT_CYC - 1);
    // Done rises one edge after the last synced sample is captured
    localparam int RD_DONE_DLY = EMS_RD_WAIT_CYC + 1;

    logic [3:0] cfg_s;
    logic [31:0] ed_in_s;
    ems_rst_state_t rst_st_r;
    ems_acc_state_t acc_st_r;
    logic [HCW-1:0] hold_cnt_r;
    logic little_r;
    logic fix_r;
    logic [1:0] boot_r;
    logic int_rst_n_r;
    logic start_r;
    logic [1:0] acc_width_r;
    logic [1:0] rd_cnt_r;
    logic done_r;
    logic [31:0] rdata_r;
    logic [31:0] ed_out_r;
    logic [3:0] ed_oe_r;

    // Pin synchronisers
    ems_sync #(.W(4)) u_cfg_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async({i_boot_mode_pin, i_lane_correct_pin, i_endian_select_pin}),
        .o_sync(cfg_s)
    );
    ems_sync #(.W(EMS_BUS_W)) u_data_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(i_ext_data_bus),
        .o_sync(ed_in_s)
    );

    // Lane placement
    wire top_align = ~little_r & fix_r;
    wire hold_done = (rst_st_r == EMS_ST_HOLD) && (hold_cnt_r == HOLD_LAST);
    wire running = (rst_st_r == EMS_ST_RUN);
    wire take = i_acc_req && o_acc_ready;
    wire take_wr = take && i_acc_we;
    wire take_rd = take && !i_acc_we;
    wire rd_last = (acc_st_r == EMS_AC_READ) && (rd_cnt_r == RD_LAST);
    wire w_is8 = (i_acc_width == EMS_WIDTH_8);
    wire w_is16 = (i_acc_width == EMS_WIDTH_16);
    wire [31:0] wr8 = top_align ? {i_acc_wdata[7:0], 24'h000000} :
        {24'h000000, i_acc_wdata[7:0]};
    wire [31:0] wr16 = top_align ? {i_acc_wdata[15:0], 16'h0000} :
        {16'h0000, i_acc_wdata[15:0]};
    wire [3:0] oe8 = top_align ? EMS_OE_TOP8 : EMS_OE_LOW8;
    wire [3:0] oe16 = top_align ? EMS_OE_TOP16 : EMS_OE_LOW16;
    wire [31:0] wr_sel = w_is8 ? wr8 : (w_is16 ? wr16 : i_acc_wdata);
    wire [3:0] oe_sel = w_is8 ? oe8 : (w_is16 ? oe16 : EMS_OE_ALL);
    wire [31:0] rd8 = top_align ? {24'h000000, ed_in_s[31:24]} :
        {24'h000000, ed_in_s[7:0]};
    wire [31:0] rd16 = top_align ? {16'h0000, ed_in_s[31:16]} :
        {16'h0000, ed_in_s[15:0]};
    wire [31:0] rd_sel = (acc_width_r == EMS_WIDTH_8) ? rd8 :
        ((acc_width_r == EMS_WIDTH_16) ? rd16 : ed_in_s);

    // Reset hold and configuration capture
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_st_r <= EMS_ST_HOLD;
            hold_cnt_r <= '0;
            int_rst_n_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            start_r <= hold_done;
            if (hold_done) begin
                rst_st_r <= EMS_ST_RUN;
                int_rst_n_r <= 1'b1;
            end else if (!running) begin
                hold_cnt_r <= hold_cnt_r + HCW'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            little_r <= EMS_LITTLE_RST;
            fix_r <= EMS_FIX_RST;
            boot_r <= EMS_BOOT_RST;
        end else if (!running) begin
            little_r <= cfg_s[0];
            fix_r <= cfg_s[1];
            boot_r <= cfg_s[3:2];
        end
    end

    // Access sequencing
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_st_r <= EMS_AC_IDLE;
            rd_cnt_r <= 2'h0;
            acc_width_r <= EMS_WIDTH_32;
        end else begin
            if (take) begin
                acc_width_r <= i_acc_width;
            end
            if (take_rd) begin
                acc_st_r <= EMS_AC_READ;
                rd_cnt_r <= 2'h0;
            end else if (rd_last) begin
                acc_st_r <= EMS_AC_IDLE;
            end else if (acc_st_r == EMS_AC_READ) begin
                rd_cnt_r <= rd_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ed_out_r <= 32'h00000000;
            ed_oe_r <= EMS_OE_NONE;
            rdata_r <= 32'h00000000;
            done_r <= 1'b0;
        end else begin
            done_r <= take_wr || rd_last;
            ed_oe_r <= take_wr ? oe_sel : EMS_OE_NONE;
            if (take_wr) begin
                ed_out_r <= wr_sel;
            end
            if (rd_last) begin
                rdata_r <= rd_sel;
            end
        end
    end

    // Outputs
    assign o_int_rst_n = int_rst_n_r;
    assign o_cpu_start = start_r;
    assign o_boot_mode = boot_r;
    assign o_little_endian_mode = little_r;
    assign o_big_endian_lane_fix = fix_r;
    assign o_acc_ready = running && (acc_st_r == EMS_AC_IDLE);
    assign o_acc_done = done_r;
    assign o_acc_rdata = rdata_r;
    assign o_ext_data_bus = ed_out_r;
    assign o_ext_data_oe = ed_oe_r;

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    AST_LE_LOW8: assert property (
        (ed_oe_r != EMS_OE_NONE) && little_r && (acc_width_r == EMS_WIDTH_8)
        |-> (ed_oe_r == EMS_OE_LOW8))
        else $error("little endian 8-bit not on low lane");
    AST_BE_TOP8: assert property (
        take_wr && !little_r && fix_r && w_is8
        |=> (ed_oe_r == EMS_OE_TOP8) &&
            (ed_out_r[31:24] == $past(i_acc_wdata[7:0])))
        else $error("big endian 8-bit not on top lane");
    AST_BE_RD16: assert property (
        rd_last && top_align && (acc_width_r == EMS_WIDTH_16)
        |=> o_acc_rdata == {16'h0000, $past(ed_in_s[31:16])})
        else $error("big endian 16-bit read from wrong lanes");
    AST_LE_LOW16: assert property (
        take_wr && little_r && w_is16
        |=> (ed_oe_r == EMS_OE_LOW16) &&
            (ed_out_r[15:0] == $past(i_acc_wdata[15:0])))
        else $error("little endian 16-bit not on low lanes");
    AST_NOFIX_LOW: assert property (
        (ed_oe_r != EMS_OE_NONE) && !fix_r
        |-> (ed_oe_r == EMS_OE_LOW8) || (ed_oe_r == EMS_OE_LOW16) ||
            (ed_oe_r == EMS_OE_ALL))
        else $error("uncorrected narrow data off the low lanes");
    AST_LE_NOFIX: assert property (
        (ed_oe_r != EMS_OE_NONE) && little_r
        |-> (ed_oe_r == EMS_OE_LOW8) || (ed_oe_r == EMS_OE_LOW16) ||
            (ed_oe_r == EMS_OE_ALL))
        else $error("fix pin changed little endian placement");
    AST_HOLD: assert property (
        !running |-> !o_int_rst_n && !o_acc_ready && !o_acc_done)
        else $error("device active while held in reset");
    AST_START: assert property (
        $rose(o_int_rst_n) |-> o_cpu_start ##1 !o_cpu_start)
        else $error("processor start missing at reset release");
    AST_W32_ALL: assert property (
        take_wr && (i_acc_width == EMS_WIDTH_32)
        |=> (ed_oe_r == EMS_OE_ALL) && (ed_out_r == $past(i_acc_wdata)))
        else $error("32-bit access not on all lanes");
    AST_CFG_FROZEN: assert property (
        o_int_rst_n |=> $stable(little_r) && $stable(fix_r) &&
            $stable(boot_r))
        else $error("configuration changed after reset release");
    AST_RD_LAT: assert property (
        take_rd |-> ##RD_DONE_DLY o_acc_done)
        else $error("read answer late");

    COV_BE_W8: cover property (take_wr && top_align && w_is8);
    COV_NOFIX_BE_RD: cover property (rd_last && !little_r && !fix_r);
    COV_START: cover property ($rose(o_int_rst_n));
    COV_B2B_WR: cover property (take_wr ##1 take_wr);
endmodule : ems_lane_steer
`default_nettype wire

// >>> core/ems_pkg.sv
// Shared constants for the external memory lane steering block
package ems_pkg;
    // External data bus shape
    localparam int EMS_BUS_W = 32;
    localparam int EMS_LANES = 4;
    // Memory width codes
    localparam logic [1:0] EMS_WIDTH_8 = 2'h0;
    localparam logic [1:0] EMS_WIDTH_16 = 2'h1;
    localparam logic [1:0] EMS_WIDTH_32 = 2'h2;
    // Lane enable patterns
    localparam logic [3:0] EMS_OE_NONE = 4'h0;
    localparam logic [3:0] EMS_OE_LOW8 = 4'h1;
    localparam logic [3:0] EMS_OE_LOW16 = 4'h3;
    localparam logic [3:0] EMS_OE_TOP8 = 4'h8;
    localparam logic [3:0] EMS_OE_TOP16 = 4'hc;
    localparam logic [3:0] EMS_OE_ALL = 4'hf;
    // Reset values of captured configuration
    localparam logic EMS_LITTLE_RST = 1'b1;
    localparam logic EMS_FIX_RST = 1'b1;
    localparam logic [1:0] EMS_BOOT_RST = 2'h0;
    // Timing
    localparam int EMS_CLK_NS = 20;
    localparam int EMS_RST_HOLD_NS = 200;
    localparam int EMS_RST_HOLD_CYC =
        (EMS_RST_HOLD_NS + EMS_CLK_NS - 1) / EMS_CLK_NS;
    localparam int EMS_SYNC_STAGES = 2;
    localparam int EMS_RD_WAIT_CYC = EMS_SYNC_STAGES;
    // State machines
    typedef enum logic {EMS_ST_HOLD, EMS_ST_RUN} ems_rst_state_t;
    typedef enum logic [1:0] {EMS_AC_IDLE, EMS_AC_READ} ems_acc_state_t;
endpackage : ems_pkg

// >>> core/ems_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module ems_sync
    import ems_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : ems_sync
`default_nettype wire

// >>> core/ems_top_note.sv
// Spare source slot that holds no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> bench/ems_mem_model.sv
// Behavioural external memory on the shared data bus
`timescale 1ns/1ns
`default_nettype none
module ems_mem_model
    import ems_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Device side of the bus
    input wire logic [31:0] i_drv_data,
    input wire logic [3:0] i_drv_oe,
    // Level on the bus pins
    output logic [31:0] o_bus_level
);
    logic [31:0] mem_r = 32'h5aa5_c33c;
    // Stores the driven lanes
    always @(posedge i_sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (i_drv_oe[i]) begin
                mem_r[8*i +: 8] <= i_drv_data[8*i +: 8];
            end
        end
    end
    // Driven lanes show the device, the rest the memory
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_bus_level[8*i +: 8] = i_drv_oe[i] ? i_drv_data[8*i +: 8]
                                                : mem_r[8*i +: 8];
        end
    end
endmodule : ems_mem_model
`default_nettype wire

// >>> bench/ems_lane_steer_tb_top.sv
// Testbench for the lane steering block
`timescale 1ns/1ns
`default_nettype none
module ems_lane_steer_tb_top
    import ems_pkg::*;
;
    localparam int HOLD = 3;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic endian_pin = 1'b1;
    logic fix_pin = 1'b1;
    logic [1:0] boot_pin = 2'h0;
    logic acc_req = 1'b0;
    logic acc_we = 1'b0;
    logic [1:0] acc_width = 2'h0;
    logic [31:0] acc_wdata = 32'h0;
    logic int_rst_n, cpu_start, little, lane_fix, acc_ready, acc_done;
    logic [1:0] boot_mode;
    logic [31:0] acc_rdata, bus_in, bus_out;
    logic [3:0] bus_oe;
    logic top;
    logic [31:0] shadow = 32'h5aa5_c33c;
    int fail_count = 0;
    int n_compared = 0;

    ems_lane_steer #(.HOLD_CYC(HOLD)) i_ems_lane_steer (
        .i_sys_clk(sys_clk), .i_nrst(nrst),
        .i_endian_select_pin(endian_pin), .i_lane_correct_pin(fix_pin),
        .i_boot_mode_pin(boot_pin), .o_int_rst_n(int_rst_n),
        .o_cpu_start(cpu_start), .o_boot_mode(boot_mode),
        .o_little_endian_mode(little), .o_big_endian_lane_fix(lane_fix),
        .i_acc_req(acc_req), .i_acc_we(acc_we), .i_acc_width(acc_width),
        .i_acc_wdata(acc_wdata), .o_acc_ready(acc_ready),
        .o_acc_done(acc_done), .o_acc_rdata(acc_rdata),
        .i_ext_data_bus(bus_in), .o_ext_data_bus(bus_out),
        .o_ext_data_oe(bus_oe));
    ems_mem_model i_ems_mem_model (.i_sys_clk(sys_clk),
        .i_drv_data(bus_out), .i_drv_oe(bus_oe), .o_bus_level(bus_in));

    always #10 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    function automatic logic [3:0] f_oe(input logic [1:0] w);
        if (w == EMS_WIDTH_8) return top ? EMS_OE_TOP8 : EMS_OE_LOW8;
        if (w == EMS_WIDTH_16) return top ? EMS_OE_TOP16 : EMS_OE_LOW16;
        return EMS_OE_ALL;
    endfunction : f_oe

    function automatic logic [31:0] f_mask(input logic [1:0] w);
        logic [3:0] o;
        o = f_oe(w);
        return {{8{o[3]}}, {8{o[2]}}, {8{o[1]}}, {8{o[0]}}};
    endfunction : f_mask

    function automatic int f_sh(input logic [1:0] w);
        if (!top || w == EMS_WIDTH_32) return 0;
        return (w == EMS_WIDTH_8) ? 24 : 16;
    endfunction : f_sh

    // Reset with given pins, then check the boot sequence
    task automatic t_reset(input logic le, input logic fx,
                           input logic [1:0] bm);
        int n;
        nrst = 1'b0;
        endian_pin = le;
        fix_pin = fx;
        boot_pin = bm;
        #1;
        chk(int_rst_n, 1'b0);
        repeat (20) step();
        chk(bus_oe, EMS_OE_NONE);
        nrst = 1'b1;
        n = 0;
        while (int_rst_n !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk(n, HOLD);
        chk(cpu_start, 1'b1);
        chk(boot_mode, bm);
        chk(little, le);
        chk(lane_fix, fx);
        step();
        chk(cpu_start, 1'b0);
        top = !le && fx;
        endian_pin = !le;
        fix_pin = !fx;
        repeat (4) step();
        chk(little, le);
        chk(lane_fix, fx);
    endtask : t_reset

    // Write one unit and check lanes on the pins
    task automatic t_wr(input logic [1:0] w, input logic [31:0] d);
        logic [31:0] m;
        logic [31:0] e;
        m = f_mask(w);
        e = d << f_sh(w);
        acc_req = 1'b1;
        acc_we = 1'b1;
        acc_width = w;
        acc_wdata = d;
        step();
        acc_req = 1'b0;
        chk(acc_done, 1'b1);
        chk(bus_oe, f_oe(w));
        chk(bus_out & m, e & m);
        shadow = (shadow & ~m) | (e & m);
        step();
        chk(bus_oe, EMS_OE_NONE);
    endtask : t_wr

    // Read one unit back from its lanes
    task automatic t_rd(input logic [1:0] w);
        acc_req = 1'b1;
        acc_we = 1'b0;
        acc_width = w;
        step();
        acc_req = 1'b0;
        chk(acc_ready, 1'b0);
        step();
        step();
        chk(acc_done, 1'b1);
        chk(acc_rdata, (shadow & f_mask(w)) >> f_sh(w));
    endtask : t_rd

    initial begin
        #100000;
        fail_count++;
        close_out();
    end

    initial begin
        for (int c = 0; c < 4; c++) begin
            step();
            t_reset(c < 2, c[0] == 1'b0, c[1:0]);
            t_wr(EMS_WIDTH_8, 32'hffff_ff00 | (32'h11 * (c + 1)));
            t_rd(EMS_WIDTH_8);
            t_wr(EMS_WIDTH_16, 32'hffff_0000 | (32'h1357 + c));
            t_rd(EMS_WIDTH_16);
            t_wr(EMS_WIDTH_32, 32'h8642_0000 | c);
            t_rd(EMS_WIDTH_32);
        end
        close_out();
    end
endmodule : ems_lane_steer_tb_top
`default_nettype wire
